/* File: receiver_gain_control_test.sv */
// receiver_gain_control_test.sv: self-checking testbench of the receiver gain control block
`timescale 1ns/1ps
module receiver_gain_control_test;
    import rgc_pkg::*;
    logic pclk, presetn, ce, psel, penable, pwrite, rssi_valid, buffer_drained;
    logic correction_active, bit_tick, pready, pslverr, waiting, serr;
    logic [7:0] paddr, rssi_sample, amplitude;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] amp_gain_code;
    logic [4:0] filter_width_sel;
    logic signed [9:0] ref_level;
    logic [5:0] digital_gain;
    int err_total, n_checks;
    // table of gain cases: choice [15:12], strength [11:4], expected step [3:0]
    logic [15:0] gtab [14] = '{16'h0701, 16'h0802, 16'h0903, 16'h0A84, 16'h0BE5, 16'h0D06, 16'h1901,
                               16'h2902, 16'h3903, 16'h4904, 16'h5905, 16'h6906, 16'h7903, 16'h0903};

    rgc_top #(.ADDR_W(8)) DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rssi_valid(rssi_valid), .rssi_sample(rssi_sample), .buffer_drained(buffer_drained),
        .correction_active(correction_active), .bit_tick(bit_tick), .amplitude(amplitude),
        .amp_gain_code(amp_gain_code), .waiting(waiting), .filter_width_sel(filter_width_sel),
        .ref_level(ref_level), .digital_gain(digital_gain));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // apb transfer: request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // one-cycle pulse on a strobe input; the wait in front keeps pulses apart
    task automatic samp(input logic [7:0] s);
        @(posedge pclk);
        rssi_valid <= 1'b1; rssi_sample <= s;
        @(posedge pclk);
        rssi_valid <= 1'b0;
    endtask

    task automatic drain();
        @(posedge pclk);
        buffer_drained <= 1'b1;
        @(posedge pclk);
        buffer_drained <= 1'b0;
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        apb(0, RGC_OFS_TRIG, 0); check("trig rst", rd, 32'h0000_00E4);
        apb(0, RGC_OFS_CTRL, 0); check("ctrl rst", rd, 32'h0000_0000);
        apb(0, RGC_OFS_DGC, 0); check("dgc rst", rd, 32'h0000_0030);
        apb(0, 8'h40, 0); check("unmapped err", {31'h0, serr}, 32'h1);
        check("ref level", {22'h0, ref_level}, {22'h0, 10'h392});
        $display("test regs done");
    endtask

    // correction running picks the correction width, else the normal one
    task automatic t_width();
        apb(1, RGC_OFS_WIDTH, 32'h0000_0015);
        @(posedge pclk) correction_active <= 1'b1;
        repeat (3) @(posedge pclk);
        check("width cor", {27'h0, filter_width_sel}, 32'h00);
        check("ref widest", {22'h0, ref_level}, {22'h0, 10'h3A2});
        correction_active <= 1'b0;
        repeat (3) @(posedge pclk);
        check("width norm", {27'h0, filter_width_sel}, 32'h15);
        check("ref norm", {22'h0, ref_level}, {22'h0, 10'h392});
        $display("test width done");
    endtask

    // every choice code; a low sample mid-run must restart the two-sample count
    task automatic t_gain();
        apb(1, RGC_OFS_TRIG, 32'h10);
        foreach (gtab[i]) begin
            apb(1, RGC_OFS_CTRL, 32'h10 | gtab[i][15:12]);
            samp(gtab[i][11:4]); samp(8'h05); samp(gtab[i][11:4]);
            repeat (3) @(posedge pclk);
            check("still wait", {31'h0, waiting}, 32'h1);
            samp(gtab[i][11:4]);
            repeat (3) @(posedge pclk);
            check("hold", {31'h0, waiting}, 32'h0);
            check("gain", {29'h0, amp_gain_code}, {28'h0, gtab[i][3:0]});
            apb(0, RGC_OFS_STATUS, 0); check("status gain", rd & 32'h7, {28'h0, gtab[i][3:0]});
            if (i == 13) break;
            apb(1, RGC_OFS_CTRL, 32'h110 | gtab[i][15:12]);
            repeat (2) @(posedge pclk);
            check("rearm wait", {31'h0, waiting}, 32'h1);
            apb(0, RGC_OFS_CTRL, 0); check("rearm clr", rd & 32'h100, 32'h0);
        end
        $display("test gain done");
    endtask

    // packet end without and with auto re-arm, then continuous mode
    task automatic t_packet();
        drain(); repeat (200) @(posedge pclk);
        check("keep gain", {31'h0, waiting}, 32'h0);
        apb(1, RGC_OFS_HOLDOFF, 32'h1); apb(1, RGC_OFS_CTRL, 32'h18);
        drain(); repeat (100) @(posedge pclk);
        check("holdoff", {31'h0, waiting}, 32'h0);
        repeat (40) @(posedge pclk);
        check("auto rearm", {31'h0, waiting}, 32'h1);
        apb(1, RGC_OFS_CTRL, 32'h30); samp(8'h90); samp(8'h90); drain();
        repeat (200) @(posedge pclk);
        check("cont hold", {31'h0, waiting}, 32'h0);
        apb(1, RGC_OFS_CTRL, 32'h130); repeat (2) @(posedge pclk);
        check("cont rearm", {31'h0, waiting}, 32'h1);
        $display("test packet done");
    endtask

    // one bit tick pulse, then time for the tracker to settle
    task automatic tick();
        @(posedge pclk) bit_tick <= 1'b1;
        @(posedge pclk) bit_tick <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    // amplitude sits below target, so gain climbs by two (wide) or one (narrow) every second tick
    task automatic t_track();
        apb(1, RGC_OFS_DGC, 32'h30);
        tick();
        check("dgain one tick", {26'h0, digital_gain}, 32'h20);
        tick();
        check("dgain step", {26'h0, digital_gain}, 32'h22);
        apb(1, RGC_OFS_DGC, 32'h20);
        tick(); tick();
        check("dgain narrow", {26'h0, digital_gain}, 32'h23);
        apb(1, RGC_OFS_DGC, 32'h00);
        repeat (2) @(posedge pclk);
        check("dgain off", {26'h0, digital_gain}, 32'h20);
        $display("test track done");
    endtask

    // ----------------------------------------------------------------
    // clock, reset, sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    initial begin
        {presetn, psel, penable, pwrite, rssi_valid, buffer_drained, correction_active, bit_tick} = '0;
        ce = 1'b1; paddr = '0; pwdata = '0; rssi_sample = '0; amplitude = 8'h40;
        err_total = 0; n_checks = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs(); t_track(); t_width(); t_gain(); t_packet();
        end_of_test();
    end

    // about 1000 cycles expected; far beyond that means a hang
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        end_of_test();
    end
endmodule

/* File: rgc_band_pick.sv */
// rgc_band_pick.sv: maps a signal strength onto one of six amplifier gain steps
`timescale 1ns/1ps
module rgc_band_pick
    import rgc_pkg::*;
(
    input wire logic [7:0] strength,
    input wire logic [39:0] levels,
    output logic [2:0] step
);
    // --------------------------------------------------------------
    // band compare
    // --------------------------------------------------------------
    // step one is max gain; each level crossed costs one step
    always_comb begin
        step = 3'h1;
        for (int i = 0; i < 5; i++) begin
            if (strength > levels[i*8 +: 8]) begin
                step = 3'(i + 2);
            end
        end
    end
endmodule

/* File: rgc_dgain_track.sv */
// rgc_dgain_track.sv: digital gain tracker stepping once every two bit periods
`timescale 1ns/1ps
module rgc_dgain_track
    import rgc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    rgc_trk_if.trk trk
);
    typedef struct packed {
        logic [1:0] bits;
        logic [5:0] dgain;
    } rgc_trk_type;

    rgc_trk_type s_r;
    rgc_trk_type s_nxt;

    // --------------------------------------------------------------
    // tracking step
    // --------------------------------------------------------------
    // runs whatever the amplifier does, so fades inside a frozen packet are caught
    always_comb begin
        s_nxt = s_r;
        if (!trk.enable) begin
            s_nxt.bits = 2'h0;
            s_nxt.dgain = RGC_DGAIN_RST;
        end else if (trk.bit_tick) begin
            s_nxt.bits = s_r.bits + 2'h1;
            if (s_r.bits == 2'(RGC_TRACK_BITS - 1)) begin
                s_nxt.bits = 2'h0;
                if (trk.amplitude < RGC_AMP_TARGET && s_r.dgain < 6'h3E) begin
                    s_nxt.dgain = s_r.dgain + (trk.wide_step ? 6'h2 : 6'h1);
                end else if (trk.amplitude > RGC_AMP_TARGET && s_r.dgain > 6'h01) begin
                    s_nxt.dgain = s_r.dgain - (trk.wide_step ? 6'h2 : 6'h1);
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{bits: 2'h0, dgain: RGC_DGAIN_RST};
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign trk.dgain = s_r.dgain;

    a_dgain_two_bits: assert property (@(posedge pclk) disable iff (!presetn)
        ($changed(s_r.dgain) && $past(trk.enable)) |-> $past(ce && trk.bit_tick && s_r.bits == 2'h1))
        else $error("digital gain moved off the two-bit boundary");
endmodule

/* File: rgc_pkg.sv */
// rgc_pkg.sv: shared constants and types of the receiver gain control block
package rgc_pkg;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] RGC_OFS_CTRL = 8'h00;
    localparam logic [7:0] RGC_OFS_TRIG = 8'h04;
    localparam logic [7:0] RGC_OFS_BAND_LO = 8'h08;
    localparam logic [7:0] RGC_OFS_BAND_HI = 8'h0C;
    localparam logic [7:0] RGC_OFS_HOLDOFF = 8'h10;
    localparam logic [7:0] RGC_OFS_DGC = 8'h14;
    localparam logic [7:0] RGC_OFS_WIDTH = 8'h18;
    localparam logic [7:0] RGC_OFS_STATUS = 8'h1C;
    localparam logic [7:0] RGC_OFS_REF = 8'h20;

    // ----------------------------------------------------------------
    // control, digital gain and width register fields
    // ----------------------------------------------------------------
    localparam int RGC_CTRL_CHOICE_LSB = 0;
    localparam int RGC_CTRL_AUTO_BIT = 3;
    localparam int RGC_CTRL_ENABLE_BIT = 4;
    localparam int RGC_CTRL_CONT_BIT = 5;
    localparam int RGC_CTRL_REARM_BIT = 8;
    localparam int RGC_DGC_ON_BIT = 5;
    localparam int RGC_DGC_WIDE_BIT = 4;
    localparam int RGC_WIDTH_COR_LSB = 8;

    // ----------------------------------------------------------------
    // reset values and the tracker amplitude target
    // ----------------------------------------------------------------
    localparam logic [2:0] RGC_CHOICE_RST = 3'h0;
    localparam logic [2:0] RGC_GAIN_RST = 3'h1;
    localparam logic [7:0] RGC_TRIG_RST = 8'hE4;
    localparam logic [39:0] RGC_BANDS_RST = 40'hC8_B4_A0_8C_78;
    localparam logic [3:0] RGC_HOLDOFF_RST = 4'h0;
    localparam logic [7:0] RGC_DGC_RST = 8'h30;
    localparam logic [4:0] RGC_WIDTH_RST = 5'h15;
    localparam logic [5:0] RGC_DGAIN_RST = 6'h20;
    localparam logic [7:0] RGC_AMP_TARGET = 8'h80;

    // ----------------------------------------------------------------
    // gain codes and reference figures
    // ----------------------------------------------------------------
    localparam logic [2:0] RGC_CHOICE_AUTO = 3'h0;
    localparam logic [2:0] RGC_CHOICE_RSVD = 3'h7;
    localparam int RGC_FLOOR_DBM = -174;
    localparam int RGC_NOISE_FIG_DB = 7;
    localparam int RGC_DEMOD_SNR_DB = 8;
    localparam int RGC_FADE_MARGIN_DB = 5;
    localparam int RGC_BW_M16_DB = 60;
    localparam int RGC_BW_M20_DB = 59;
    localparam int RGC_BW_M24_DB = 58;
    localparam int RGC_DB_PER_EXP = 3;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int RGC_CLK_PERIOD_NS = 8;
    localparam int RGC_HOLDOFF_UNIT_NS = 1000;
    localparam int RGC_HOLDOFF_UNIT_CYC = (RGC_HOLDOFF_UNIT_NS + RGC_CLK_PERIOD_NS - 1) / RGC_CLK_PERIOD_NS;
    localparam int RGC_TRACK_BITS = 2;

    // receiver sequencing states, one-hot
    typedef enum logic [3:0] {
        RGC_OFF = 4'h1,
        RGC_WAIT = 4'h2,
        RGC_HOLD = 4'h4,
        RGC_HOLDOFF = 4'h8
    } rgc_state_type;

endpackage

/* File: rgc_top.sv */
// rgc_top.sv: receiver gain control sequencer with its apb register file
`timescale 1ns/1ps
// What this block does
// - gain choice zero lets the loop pick the gain, one to six force max gain down to minus 48 dB, seven is reserved.
// - once enabled the receiver waits until signal strength beats the trigger level on two samples in a row.
// - after the wait the gain step is picked from the bands bounded by five successive levels.
// - the picked step holds for the packet and is readable as the applied gain until a re-arm.
// - in packet mode without auto re-arm the same gain carries on into the next packet.
// - in packet mode with auto re-arm the receiver goes back to waiting once the buffer drains and the holdoff ends.
// - in packet mode a written re-arm command always sends the receiver back to waiting for a new gain pick.
// - in continuous mode the gain is kept until the re-arm command sends the receiver back to waiting.
// - while frequency correction runs at startup the correction channel width is used instead of the normal one.
// - the reference level is -174 dBm plus 7 dB, 8 dB, ten log of twice the width, and 5 dB.
// - the digital gain tracker re-adjusts every two bit periods whatever the amplifier gain does.
module rgc_top
    import rgc_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rssi_valid,
    input wire logic [7:0] rssi_sample,
    input wire logic buffer_drained,
    input wire logic correction_active,
    input wire logic bit_tick,
    input wire logic [7:0] amplitude,
    output logic [2:0] amp_gain_code,
    output logic waiting,
    output logic [4:0] filter_width_sel,
    output logic signed [9:0] ref_level,
    output logic [5:0] digital_gain
);
    typedef struct packed {
        rgc_state_type st;
        logic hit;
        logic [10:0] hold_cnt;
        logic [2:0] gain;
        logic [2:0] amp_gain_choice;
        logic auto_receive_rearm;
        logic rx_enable;
        logic cont_mode;
        logic receive_rearm_cmd;
        logic [7:0] strength_trigger_level;
        logic [39:0] bands;
        logic [3:0] rearm_holdoff;
        logic [7:0] digital_gain_config;
        logic [4:0] channel_filter_width;
        logic [4:0] correction_channel_width;
        logic [7:0] signal_strength_value;
        logic [4:0] width_sel;
        logic signed [9:0] ref_lvl;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } rgc_regs_type;

    rgc_regs_type r_r;
    rgc_regs_type r_nxt;
    logic [2:0] pick_step;
    logic [5:0] dgain_w;
    logic above;
    logic take;
    logic wr_en;
    logic [31:0] rd_word;
    logic rd_ok;
    logic [4:0] width_w;
    logic signed [9:0] ref_w;

    rgc_trk_if trk_bus ();

    // --------------------------------------------------------------
    // sub blocks
    // --------------------------------------------------------------
    rgc_band_pick u_pick (
        .strength(rssi_sample),
        .levels(r_r.bands),
        .step(pick_step)
    );

    rgc_dgain_track u_track (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .trk(trk_bus.trk)
    );

    // tracker enable and step size come straight from the config byte
    assign trk_bus.bit_tick = bit_tick;
    assign trk_bus.amplitude = amplitude;
    assign trk_bus.enable = r_r.digital_gain_config[RGC_DGC_ON_BIT];
    assign trk_bus.wide_step = r_r.digital_gain_config[RGC_DGC_WIDE_BIT];
    assign dgain_w = trk_bus.dgain;

    // --------------------------------------------------------------
    // reference level
    // --------------------------------------------------------------
    // width code: bits 1:0 mantissa select (16/20/24), bits 4:2 exponent
    always_comb begin
        int bw_db;
        bw_db = RGC_BW_M16_DB;
        width_w = correction_active ? r_r.correction_channel_width : r_r.channel_filter_width;
        case (width_w[1:0])
            2'h0: bw_db = RGC_BW_M16_DB;
            2'h1: bw_db = RGC_BW_M20_DB;
            default: bw_db = RGC_BW_M24_DB;
        endcase
        bw_db = bw_db - RGC_DB_PER_EXP * int'(width_w[4:2]);
        ref_w = 10'(RGC_FLOOR_DBM + RGC_NOISE_FIG_DB + RGC_DEMOD_SNR_DB + bw_db + RGC_FADE_MARGIN_DB);
    end

    // --------------------------------------------------------------
    // register read mux
    // --------------------------------------------------------------
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        case (paddr[7:0])
            RGC_OFS_CTRL: rd_word = {23'h0, r_r.receive_rearm_cmd, 2'h0, r_r.cont_mode, r_r.rx_enable,
                                     r_r.auto_receive_rearm, r_r.amp_gain_choice};
            RGC_OFS_TRIG: rd_word = {24'h0, r_r.strength_trigger_level};
            RGC_OFS_BAND_LO: rd_word = r_r.bands[31:0];
            RGC_OFS_BAND_HI: rd_word = {24'h0, r_r.bands[39:32]};
            RGC_OFS_HOLDOFF: rd_word = {28'h0, r_r.rearm_holdoff};
            RGC_OFS_DGC: rd_word = {24'h0, r_r.digital_gain_config};
            RGC_OFS_WIDTH: rd_word = {19'h0, r_r.correction_channel_width, 3'h0, r_r.channel_filter_width};
            RGC_OFS_STATUS: rd_word = {2'h0, dgain_w, r_r.signal_strength_value, 4'h0, r_r.st,
                                       5'h0, r_r.gain};
            RGC_OFS_REF: rd_word = {{22{r_r.ref_lvl[9]}}, r_r.ref_lvl};
            default: rd_ok = 1'b0;
        endcase
    end

    // --------------------------------------------------------------
    // sequencer and registers
    // --------------------------------------------------------------
    assign above = rssi_valid && (rssi_sample > r_r.strength_trigger_level);
    assign take = (r_r.st == RGC_WAIT) && above && r_r.hit && !r_r.receive_rearm_cmd;
    assign wr_en = psel && penable && r_r.pready && pwrite;

    always_comb begin
        r_nxt = r_r;
        r_nxt.width_sel = width_w;
        r_nxt.ref_lvl = ref_w;
        if (above) begin
            r_nxt.signal_strength_value = rssi_sample;
        end
        case (r_r.st)
            RGC_OFF: begin
                if (r_r.rx_enable) begin
                    r_nxt.st = RGC_WAIT;
                    r_nxt.hit = 1'b0;
                end
            end
            RGC_WAIT: begin
                // a sample at or below the trigger breaks the run of two
                if (rssi_valid) begin
                    r_nxt.hit = above;
                end
                if (take) begin
                    r_nxt.st = RGC_HOLD;
                    r_nxt.hit = 1'b0;
                    if (r_r.amp_gain_choice == RGC_CHOICE_AUTO || r_r.amp_gain_choice == RGC_CHOICE_RSVD) begin
                        r_nxt.gain = pick_step;
                    end else begin
                        r_nxt.gain = r_r.amp_gain_choice;
                    end
                end
            end
            RGC_HOLD: begin
                // without auto re-arm the gain simply carries into the next packet
                if (!r_r.cont_mode && r_r.auto_receive_rearm && buffer_drained) begin
                    r_nxt.st = RGC_HOLDOFF;
                    r_nxt.hold_cnt = 11'(int'(r_r.rearm_holdoff) * RGC_HOLDOFF_UNIT_CYC);
                end
            end
            RGC_HOLDOFF: begin
                // lets the far transmitter ramp down before strength is trusted again
                if (r_r.hold_cnt == 11'h000) begin
                    r_nxt.st = RGC_WAIT;
                    r_nxt.hit = 1'b0;
                end else begin
                    r_nxt.hold_cnt = r_r.hold_cnt - 11'h001;
                end
            end
            default: r_nxt.st = RGC_OFF;
        endcase
        // the re-arm command overrides everything while enabled
        if (r_r.receive_rearm_cmd && r_r.st != RGC_OFF) begin
            r_nxt.st = RGC_WAIT;
            r_nxt.hit = 1'b0;
            r_nxt.receive_rearm_cmd = 1'b0;
        end
        if (!r_r.rx_enable) begin
            r_nxt.st = RGC_OFF;
            r_nxt.receive_rearm_cmd = 1'b0;
        end
        // apb: answer one cycle after setup, so every access has one ready cycle
        r_nxt.pready = psel && !penable;
        if (psel && !penable) begin
            r_nxt.prdata = rd_ok ? rd_word : 32'h0000_0000;
            r_nxt.pslverr = !rd_ok;
        end else if (r_r.pready) begin
            r_nxt.pslverr = 1'b0;
        end
        if (wr_en && !r_r.pslverr) begin
            case (paddr[7:0])
                RGC_OFS_CTRL: begin
                    r_nxt.amp_gain_choice = pwdata[RGC_CTRL_CHOICE_LSB +: 3];
                    r_nxt.auto_receive_rearm = pwdata[RGC_CTRL_AUTO_BIT];
                    r_nxt.rx_enable = pwdata[RGC_CTRL_ENABLE_BIT];
                    r_nxt.cont_mode = pwdata[RGC_CTRL_CONT_BIT];
                    // a new command beats the self-clear of the previous one
                    if (pwdata[RGC_CTRL_REARM_BIT]) begin
                        r_nxt.receive_rearm_cmd = 1'b1;
                    end
                end
                RGC_OFS_TRIG: r_nxt.strength_trigger_level = pwdata[7:0];
                RGC_OFS_BAND_LO: r_nxt.bands[31:0] = pwdata;
                RGC_OFS_BAND_HI: r_nxt.bands[39:32] = pwdata[7:0];
                RGC_OFS_HOLDOFF: r_nxt.rearm_holdoff = pwdata[3:0];
                RGC_OFS_DGC: r_nxt.digital_gain_config = pwdata[7:0];
                RGC_OFS_WIDTH: begin
                    r_nxt.channel_filter_width = pwdata[4:0];
                    r_nxt.correction_channel_width = pwdata[RGC_WIDTH_COR_LSB +: 5];
                end
                default: r_nxt.rearm_holdoff = r_r.rearm_holdoff;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_r <= '{st: RGC_OFF, hit: 1'b0, hold_cnt: 11'h000, gain: RGC_GAIN_RST,
                     amp_gain_choice: RGC_CHOICE_RST, auto_receive_rearm: 1'b0, rx_enable: 1'b0,
                     cont_mode: 1'b0, receive_rearm_cmd: 1'b0, strength_trigger_level: RGC_TRIG_RST,
                     bands: RGC_BANDS_RST, rearm_holdoff: RGC_HOLDOFF_RST, digital_gain_config: RGC_DGC_RST,
                     channel_filter_width: RGC_WIDTH_RST, correction_channel_width: RGC_WIDTH_RST,
                     signal_strength_value: 8'h00, width_sel: RGC_WIDTH_RST, ref_lvl: 10'sh000,
                     pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000};
        end else if (ce) begin
            r_r <= r_nxt;
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign prdata = r_r.prdata;
    assign pready = r_r.pready;
    assign pslverr = r_r.pslverr;
    assign amp_gain_code = r_r.gain;
    assign waiting = r_r.st[1]; // one-hot wait bit, so the pin comes straight from its flop
    assign filter_width_sel = r_r.width_sel;
    assign ref_level = r_r.ref_lvl;
    assign digital_gain = dgain_w;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_take_manual;
        ce && take && r_r.amp_gain_choice != RGC_CHOICE_AUTO && r_r.amp_gain_choice != RGC_CHOICE_RSVD;
    endsequence
    sequence s_holdoff_end;
        ce && r_r.st == RGC_HOLDOFF && r_r.hold_cnt == 11'h000 && r_r.rx_enable && !r_r.receive_rearm_cmd;
    endsequence

    a_manual_gain_forced: assert property (s_take_manual |=> amp_gain_code == $past(r_r.amp_gain_choice))
        else $error("forced gain step not applied");
    a_wait_needs_two: assert property ((r_r.st == RGC_WAIT ##1 r_r.st == RGC_HOLD) |->
        $past(above) && $past(r_r.hit))
        else $error("wait left without two samples above trigger");
    a_auto_band_step: assert property ((ce && take && r_r.amp_gain_choice == RGC_CHOICE_AUTO) |=>
        amp_gain_code == $past(pick_step))
        else $error("automatic gain step differs from band pick");
    a_gain_held_packet: assert property ((r_r.st != RGC_WAIT) |=> $stable(amp_gain_code))
        else $error("applied gain changed outside the wait state");
    a_no_auto_stay: assert property ((ce && r_r.st == RGC_HOLD && !r_r.auto_receive_rearm && r_r.rx_enable
        && !r_r.receive_rearm_cmd && !wr_en) |=> r_r.st == RGC_HOLD)
        else $error("gain dropped without re-arm");
    a_holdoff_to_wait: assert property (s_holdoff_end |=> waiting)
        else $error("holdoff end did not return to waiting");
    a_rearm_taken: assert property ((ce && r_r.receive_rearm_cmd && r_r.rx_enable && r_r.st != RGC_OFF && !wr_en)
        |=> waiting && !r_r.receive_rearm_cmd)
        else $error("re-arm command not taken or not cleared");
    a_width_follows: assert property ((ce && correction_active) |=>
        filter_width_sel == $past(r_r.correction_channel_width))
        else $error("correction width not used during correction");
    a_ref_formula: assert property ((ce && width_w == 5'h00) |=> ref_level == 10'sh3A2)
        else $error("reference level formula wrong for widest setting");
endmodule

/* File: rgc_trk_if.sv */
// rgc_trk_if.sv: link between the sequencer and the digital gain tracker
`timescale 1ns/1ps
interface rgc_trk_if;
    logic bit_tick;
    logic [7:0] amplitude;
    logic enable;
    logic wide_step;
    logic [5:0] dgain;
    modport trk (input bit_tick, input amplitude, input enable, input wide_step, output dgain);
    modport ctl (output bit_tick, output amplitude, output enable, output wide_step, input dgain);
endinterface
